// *** hw/adc_port_consts.vh ***
// Constants for the converter serial port and control block
`ifndef ADC_PORT_CONSTS_VH
`define ADC_PORT_CONSTS_VH
`define CTL_RESET          24'h007300
`define CTL_CODING_BIT     23
`define CTL_NOTCH_HI       22
`define CTL_NOTCH_LO       12
`define CTL_MODE_HI        11
`define CTL_MODE_LO        9
`define CTL_POLARITY_BIT   8
`define CTL_GAIN_HI        7
`define CTL_GAIN_LO        5
`define CTL_BURNOUT_BIT    4
`define CTL_STANDBY_BIT    3
`define CTL_BYTE_ASC_BIT   2
`define CTL_LSB_FIRST_BIT  1
`define CTL_READ_LINE_BIT  0
`define MODE_SELF_CAL      3'h1
`define NOTCH_MIN          11'h00A
`define NOTCH_DIV          512
`define INS_DIR_BIT        7
`define INS_CNT_HI         6
`define INS_CNT_LO         5
`define INS_BANK_BIT       4
`define REG_RESULT         2'h0
`define REG_CONTROL        2'h1
`define REG_OFFSET         2'h2
`define REG_FULLSCALE      2'h3
`define FIFO_DEPTH         16
`endif

// *** hw/adc_serial_port.v ***
// Serial host port, control register and conversion result path
`include "adc_port_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  localparam AW = $clog2(DEPTH);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_reg;
  reg [AW-1:0]    rd_reg;
  reg [AW:0]      count_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (count_reg != DEPTH);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rd_reg];
  always @(posedge clk_i) begin
    if (push)
      mem_reg[wr_reg] <= in_data_i;
    if (rst_i) begin
      wr_reg    <= {AW{1'b0}};
      rd_reg    <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule

module adc_serial_port #(
  parameter OSC_DIV = 1
) (
  // Clock and reset
  input  wire        CLOCK_I,
  input  wire        SYS_RST_I,
  // Serial pins
  input  wire        SHIFT_CLK_I,
  input  wire        SELECT_N_I,
  input  wire        DATA_LINE_I,
  output reg         DATA_LINE_O,
  output reg         DATA_LINE_OE_O,
  output reg         SERIAL_DATA_OUT_O,
  output reg         SERIAL_DATA_OUT_OE_O,
  output wire        CONVERSION_READY_N_O,
  // Sample source from the modulator and filter
  input  wire [23:0] CONVERSION_WORD_I,
  input  wire        CONVERSION_VALID_I,
  output wire        CONVERSION_READY_O,
  // Control fields to the analog and filter sections
  output wire        OUTPUT_CODING_SEL_O,
  output wire [10:0] FILTER_NOTCH_CODE_O,
  output wire [2:0]  OPERATING_MODE_SEL_O,
  output wire        BIPOLAR_EN_O,
  output wire [2:0]  GAIN_SELECT_O,
  output wire        BURNOUT_CURRENT_EN_O,
  output wire        STANDBY_EN_O,
  output reg         RECALIBRATE_O,
  output reg         NOTCH_TICK_O,
  // Calibration register images
  output reg  [23:0] OFFSET_CAL_O,
  output reg  [23:0] POS_FULLSCALE_CAL_O,
  output reg  [23:0] NEG_FULLSCALE_CAL_O
);
  localparam ST_INSTR = 3'b001;
  localparam ST_DATA  = 3'b010;

  reg [23:0] converter_control_reg, conversion_result_reg;
  reg        ready_n_reg, write_reg, bank_reg, result_touched_reg;
  reg [2:0]  sclk_sync_reg, state_reg, bit_cnt_reg;
  reg [1:0]  sel_sync_reg, din_sync_reg, bytes_left_reg;
  reg [1:0]  reg_sel_reg, byte_ptr_reg;
  reg [7:0]  shift_reg, tx_byte_reg;
  reg [20:0] notch_cnt_reg;

  wire       lsb_first  = converter_control_reg[`CTL_LSB_FIRST_BIT];
  wire       byte_asc   = converter_control_reg[`CTL_BYTE_ASC_BIT];
  wire       read_line  = converter_control_reg[`CTL_READ_LINE_BIT];
  wire       standby    = converter_control_reg[`CTL_STANDBY_BIT];
  wire       bipolar    = converter_control_reg[`CTL_POLARITY_BIT];
  wire       twos_coded = converter_control_reg[`CTL_CODING_BIT];
  wire       sclk_rise  = sclk_sync_reg[1] && !sclk_sync_reg[2];
  wire       sclk_fall  = !sclk_sync_reg[1] && sclk_sync_reg[2];
  wire       selected   = !sel_sync_reg[1];
  wire       din        = din_sync_reg[1];
  wire [7:0] rx_byte    = lsb_first ? {din, shift_reg[7:1]}
                                    : {shift_reg[6:0], din};

  function [7:0] pick_byte;
    input [1:0]  sel;
    input        bank;
    input [1:0]  ptr;
    input [23:0] res, ctl, off, pos, neg;
    reg   [23:0] word;
    begin
      case (sel)
        `REG_RESULT:  word = res;
        `REG_CONTROL: word = ctl;
        `REG_OFFSET:  word = off;
        default:      word = bank ? neg : pos;
      endcase
      case (ptr)
        2'h0:    pick_byte = word[7:0];
        2'h1:    pick_byte = word[15:8];
        2'h2:    pick_byte = word[23:16];
        default: pick_byte = 8'h00;
      endcase
    end
  endfunction

  function [7:0] bit_rev;
    input [7:0] b;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        bit_rev[i] = b[7-i];
    end
  endfunction

  assign OUTPUT_CODING_SEL_O  = converter_control_reg[`CTL_CODING_BIT];
  assign FILTER_NOTCH_CODE_O  =
    converter_control_reg[`CTL_NOTCH_HI:`CTL_NOTCH_LO];
  assign OPERATING_MODE_SEL_O =
    converter_control_reg[`CTL_MODE_HI:`CTL_MODE_LO];
  assign BIPOLAR_EN_O         = bipolar;
  assign GAIN_SELECT_O        =
    converter_control_reg[`CTL_GAIN_HI:`CTL_GAIN_LO];
  assign BURNOUT_CURRENT_EN_O =
    converter_control_reg[`CTL_BURNOUT_BIT];
  assign STANDBY_EN_O         = standby;
  assign CONVERSION_READY_N_O = ready_n_reg | standby;

  // Pins cross into the system clock through two flops each; the shift clock gets a third flop for edge detection
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      sclk_sync_reg <= 3'h0;
      sel_sync_reg  <= 2'h3;
      din_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], SHIFT_CLK_I};
      sel_sync_reg  <= {sel_sync_reg[0], SELECT_N_I};
      din_sync_reg  <= {din_sync_reg[0], DATA_LINE_I};
    end
  end

  // Notch period: osc/(512*code) gives one tick per word
  wire [10:0] code_clamped = (FILTER_NOTCH_CODE_O < `NOTCH_MIN) ?
                             `NOTCH_MIN : FILTER_NOTCH_CODE_O;
  wire [20:0] notch_len    = {code_clamped, 9'h000};
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I || standby) begin
      notch_cnt_reg <= 21'h000000;
      NOTCH_TICK_O  <= 1'b0;
    end else if (notch_cnt_reg >= notch_len - 21'h000001) begin
      notch_cnt_reg <= 21'h000000;
      NOTCH_TICK_O  <= 1'b1;
    end else begin
      notch_cnt_reg <= notch_cnt_reg + 21'h000001;
      NOTCH_TICK_O  <= 1'b0;
    end
  end

  // Words wait here while a result read is in progress
  wire [23:0] fifo_word;
  wire        fifo_valid;
  wire        fifo_take = fifo_valid && ready_n_reg && !result_touched_reg;
  sample_fifo #(.WIDTH(24), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_i       (CLOCK_I),
    .rst_i       (SYS_RST_I),
    .in_data_i   (CONVERSION_WORD_I),
    .in_valid_i  (CONVERSION_VALID_I && !standby),
    .in_ready_o  (CONVERSION_READY_O),
    .out_data_o  (fifo_word),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_take)
  );

  // Unipolar is straight binary; bipolar offset binary flips the MSB
  wire [23:0] coded_word = (bipolar && !twos_coded) ?
    {~fifo_word[23], fifo_word[22:0]} : fifo_word;

  wire        last_bit  = (bit_cnt_reg == 3'h7);
  wire [1:0]  next_ptr  = byte_asc ? byte_ptr_reg + 2'h1
                                   : byte_ptr_reg - 2'h1;
  wire [7:0]  raw_byte  = pick_byte(reg_sel_reg, bank_reg, byte_ptr_reg,
                            conversion_result_reg, converter_control_reg,
                            OFFSET_CAL_O, POS_FULLSCALE_CAL_O,
                            NEG_FULLSCALE_CAL_O);
  wire [7:0]  nraw_byte = pick_byte(reg_sel_reg, bank_reg, next_ptr,
                            conversion_result_reg, converter_control_reg,
                            OFFSET_CAL_O, POS_FULLSCALE_CAL_O,
                            NEG_FULLSCALE_CAL_O);
  wire [7:0]  first_raw = pick_byte(rx_byte[3:2], rx_byte[`INS_BANK_BIT],
                            rx_byte[1:0], conversion_result_reg,
                            converter_control_reg, OFFSET_CAL_O,
                            POS_FULLSCALE_CAL_O, NEG_FULLSCALE_CAL_O);
  wire [7:0]  tx_order  = lsb_first ? bit_rev(raw_byte) : raw_byte;
  wire [7:0]  ntx_order = lsb_first ? bit_rev(nraw_byte) : nraw_byte;
  wire [7:0]  ftx_order = lsb_first ? bit_rev(first_raw) : first_raw;

  // Serial engine: instruction byte, then data bytes
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_reg             <= ST_INSTR;
      bit_cnt_reg           <= 3'h0;
      shift_reg             <= 8'h00;
      write_reg             <= 1'b0;
      bytes_left_reg        <= 2'h0;
      bank_reg              <= 1'b0;
      reg_sel_reg           <= 2'h0;
      byte_ptr_reg          <= 2'h0;
      tx_byte_reg           <= 8'h00;
      result_touched_reg    <= 1'b0;
      converter_control_reg <= `CTL_RESET;
      OFFSET_CAL_O          <= 24'h000000;
      POS_FULLSCALE_CAL_O   <= 24'h000000;
      NEG_FULLSCALE_CAL_O   <= 24'h000000;
      conversion_result_reg <= 24'h000000;
      ready_n_reg           <= 1'b1;
      RECALIBRATE_O         <= 1'b0;
    end else begin
      RECALIBRATE_O <= 1'b0;
      if (fifo_take) begin
        conversion_result_reg <= coded_word;
        ready_n_reg           <= 1'b0;
      end
      // Deselect only pauses; the position is kept until select returns
      if (selected && sclk_rise) begin
        shift_reg   <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (last_bit) begin
          case (state_reg)
            ST_INSTR: begin
              write_reg      <= rx_byte[`INS_DIR_BIT];
              bytes_left_reg <= rx_byte[`INS_CNT_HI:`INS_CNT_LO];
              bank_reg       <= rx_byte[`INS_BANK_BIT];
              reg_sel_reg    <= rx_byte[3:2];
              byte_ptr_reg   <= rx_byte[1:0];
              tx_byte_reg    <= ftx_order;
              if (rx_byte[3:2] == `REG_RESULT && !rx_byte[`INS_DIR_BIT])
                result_touched_reg <= 1'b1;
              state_reg      <= ST_DATA;
            end
            ST_DATA: begin
              if (write_reg) begin
                case (reg_sel_reg)
                  `REG_CONTROL: begin
                    case (byte_ptr_reg)
                      2'h0: converter_control_reg[7:0]   <= rx_byte;
                      2'h1: converter_control_reg[15:8]  <= rx_byte;
                      2'h2: converter_control_reg[23:16] <= rx_byte;
                      default: ;
                    endcase
                    if (byte_ptr_reg == 2'h1 || byte_ptr_reg == 2'h2) begin
                      ready_n_reg   <= 1'b1;
                      RECALIBRATE_O <= 1'b1;
                    end
                  end
                  `REG_OFFSET: begin
                    case (byte_ptr_reg)
                      2'h0: OFFSET_CAL_O[7:0]   <= rx_byte;
                      2'h1: OFFSET_CAL_O[15:8]  <= rx_byte;
                      2'h2: OFFSET_CAL_O[23:16] <= rx_byte;
                      default: ;
                    endcase
                  end
                  `REG_FULLSCALE: begin
                    case ({bank_reg, byte_ptr_reg})
                      3'h0: POS_FULLSCALE_CAL_O[7:0]   <= rx_byte;
                      3'h1: POS_FULLSCALE_CAL_O[15:8]  <= rx_byte;
                      3'h2: POS_FULLSCALE_CAL_O[23:16] <= rx_byte;
                      3'h4: NEG_FULLSCALE_CAL_O[7:0]   <= rx_byte;
                      3'h5: NEG_FULLSCALE_CAL_O[15:8]  <= rx_byte;
                      3'h6: NEG_FULLSCALE_CAL_O[23:16] <= rx_byte;
                      default: ;
                    endcase
                  end
                  default: ;
                endcase
              end
              byte_ptr_reg <= next_ptr;
              tx_byte_reg  <= ntx_order;
              if (bytes_left_reg == 2'h0) begin
                state_reg <= ST_INSTR;
                if (!write_reg && reg_sel_reg == `REG_RESULT) begin
                  ready_n_reg        <= 1'b1;
                  result_touched_reg <= 1'b0;
                end
              end else begin
                bytes_left_reg <= bytes_left_reg - 2'h1;
              end
            end
            default: state_reg <= ST_INSTR;
          endcase
        end
      end
    end
  end

  // Bits change on the falling edge and show while the clock is low, so a
  // bit cut off by a deselect comes back as soon as select returns
  wire       reading  = (state_reg == ST_DATA) && !write_reg && selected;
  wire [2:0] out_idx  = 3'h7 - bit_cnt_reg;
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      DATA_LINE_O          <= 1'b0;
      DATA_LINE_OE_O       <= 1'b0;
      SERIAL_DATA_OUT_O    <= 1'b0;
      SERIAL_DATA_OUT_OE_O <= 1'b0;
    end else if (!reading) begin
      DATA_LINE_OE_O       <= 1'b0;
      SERIAL_DATA_OUT_OE_O <= 1'b0;
    end else if (!sclk_sync_reg[1]) begin
      if (read_line) begin
        SERIAL_DATA_OUT_O    <= tx_byte_reg[out_idx];
        SERIAL_DATA_OUT_OE_O <= 1'b1;
      end else begin
        DATA_LINE_O    <= tx_byte_reg[out_idx];
        DATA_LINE_OE_O <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// *** test/adc_port_props.sv ***
// Concurrent checks on the converter serial port top-level pins
`timescale 1ns/10ps
`default_nettype none
module adc_port_checker (
  // Clock and reset
  input wire logic        CLOCK_I,
  input wire logic        SYS_RST_I,
  // Serial pins
  input wire logic        SHIFT_CLK_I,
  input wire logic        SELECT_N_I,
  input wire logic        DATA_LINE_O,
  input wire logic        DATA_LINE_OE_O,
  input wire logic        SERIAL_DATA_OUT_O,
  input wire logic        SERIAL_DATA_OUT_OE_O,
  input wire logic        CONVERSION_READY_N_O,
  // Sample path and control fields
  input wire logic        CONVERSION_VALID_I,
  input wire logic        CONVERSION_READY_O,
  input wire logic        OUTPUT_CODING_SEL_O,
  input wire logic [10:0] FILTER_NOTCH_CODE_O,
  input wire logic [2:0]  OPERATING_MODE_SEL_O,
  input wire logic        BIPOLAR_EN_O,
  input wire logic [2:0]  GAIN_SELECT_O,
  input wire logic        BURNOUT_CURRENT_EN_O,
  input wire logic        STANDBY_EN_O,
  input wire logic        NOTCH_TICK_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [10:0] code_q;
  logic [21:0] gap;
  logic        seen;
  logic        pushed;
  // Codes below the legal floor run at the floor rate
  wire  [21:0] per = (FILTER_NOTCH_CODE_O < 11'h00A ? 22'h00000A :
                      {11'h000, FILTER_NOTCH_CODE_O}) * 22'h000200;
  // Period is only judged between two ticks under one unchanged code
  always @(posedge CLOCK_I) begin
    code_q <= FILTER_NOTCH_CODE_O;
    if (SYS_RST_I) pushed <= 1'b0;
    else if (CONVERSION_VALID_I && CONVERSION_READY_O) pushed <= 1'b1;
    if (SYS_RST_I || code_q != FILTER_NOTCH_CODE_O) begin
      seen <= 1'b0;
      gap  <= 22'h000000;
    end else if (NOTCH_TICK_O) begin
      seen <= 1'b1;
      gap  <= 22'h000001;
    end else gap <= gap + 22'h000001;
  end
  sequence s_desel; SELECT_N_I [*5]; endsequence
  property p_desel_float;
    s_desel |-> !DATA_LINE_OE_O && !SERIAL_DATA_OUT_OE_O; endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("output enabled while deselected");
  property p_one_line; !(DATA_LINE_OE_O && SERIAL_DATA_OUT_OE_O); endproperty
  a_one_line: assert property (p_one_line)
    else $error("both read lines driven");
  property p_oe_selected;
    $rose(DATA_LINE_OE_O) || $rose(SERIAL_DATA_OUT_OE_O) |-> !SELECT_N_I;
  endproperty
  a_oe_selected: assert property (p_oe_selected)
    else $error("read line enabled without select");
  property p_standby_ready; STANDBY_EN_O |-> CONVERSION_READY_N_O; endproperty
  a_standby_ready: assert property (p_standby_ready)
    else $error("ready low during standby");
  property p_ready_cause;
    $fell(CONVERSION_READY_N_O) |-> pushed && !STANDBY_EN_O; endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready fell without a word");
  property p_notch_period; NOTCH_TICK_O && seen |-> gap == per; endproperty
  a_notch_period: assert property (p_notch_period)
    else $error("conversion tick period wrong");
  property p_reset_fields;
    $fell(SYS_RST_I) |-> OPERATING_MODE_SEL_O == 3'h1 && BIPOLAR_EN_O &&
      GAIN_SELECT_O == 3'h0 && !OUTPUT_CODING_SEL_O &&
      !BURNOUT_CURRENT_EN_O && !STANDBY_EN_O;
  endproperty
  a_reset_fields: assert property (p_reset_fields)
    else $error("control fields wrong after reset");
  property p_bit_on_fall;
    (DATA_LINE_OE_O && $past(DATA_LINE_OE_O) && $changed(DATA_LINE_O)) ||
    (SERIAL_DATA_OUT_OE_O && $past(SERIAL_DATA_OUT_OE_O) &&
     $changed(SERIAL_DATA_OUT_O)) |-> $past(SHIFT_CLK_I, 3) == 1'b0;
  endproperty
  a_bit_on_fall: assert property (p_bit_on_fall)
    else $error("read bit moved off a falling edge");
endmodule
bind adc_serial_port adc_port_checker u_chk (.*);
`default_nettype wire

// *** test/adc_serial_port_and_control_tb.sv ***
// Self-checking bench for the converter serial port and control block
`timescale 1ns/10ps
`default_nettype none
module adc_serial_port_and_control_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cv = 1'b0;
  logic [23:0] cw = 24'h000000;
  logic [31:0] r;
  wire         sclk, sel_n, line, dl_o, dl_oe, so, so_oe, rdy_n, crdy;
  wire         coding, bip, bo, sb, tick;
  wire  [10:0] notch;
  wire  [2:0]  mode, gain;
  wire  [23:0] offc, posc, negc;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc_n = 0;
  always #5 clk = ~clk;
  adc_serial_port DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .SHIFT_CLK_I(sclk),
    .SELECT_N_I(sel_n), .DATA_LINE_I(line), .DATA_LINE_O(dl_o),
    .DATA_LINE_OE_O(dl_oe), .SERIAL_DATA_OUT_O(so),
    .SERIAL_DATA_OUT_OE_O(so_oe), .CONVERSION_READY_N_O(rdy_n),
    .CONVERSION_WORD_I(cw), .CONVERSION_VALID_I(cv),
    .CONVERSION_READY_O(crdy), .OUTPUT_CODING_SEL_O(coding),
    .FILTER_NOTCH_CODE_O(notch), .OPERATING_MODE_SEL_O(mode),
    .BIPOLAR_EN_O(bip), .GAIN_SELECT_O(gain), .BURNOUT_CURRENT_EN_O(bo),
    .STANDBY_EN_O(sb), .RECALIBRATE_O(), .NOTCH_TICK_O(tick),
    .OFFSET_CAL_O(offc), .POS_FULLSCALE_CAL_O(posc),
    .NEG_FULLSCALE_CAL_O(negc));
  host_shift_model host (.clk_i(clk), .dev_d_i(dl_o), .dev_oe_i(dl_oe),
    .sdo_i(so), .sdo_oe_i(so_oe), .sclk_o(sclk), .sel_n_o(sel_n),
    .line_o(line));
  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      bad_count++;
      complete_run;
    end
  end
  // Offers one word and waits, bounded, for ready to fall
  task push(input [23:0] w);
    @(negedge clk);
    cw = w;
    cv = 1'b1;
    @(negedge clk);
    cv = 1'b0;
    for (int k = 0; k < 60 && rdy_n !== 1'b0; k++) @(negedge clk);
  endtask
  task t_reset_read;
    chk("reset fields", {coding, mode, bip, gain, bo, sb}, 10'h060);
    host.cyc(8'h46, 32'h0, 1'b0, 1'b0, 13, r);
    chk("ctl reset read", r[23:0], `CTL_RESET);
  endtask
  task t_ctl_write;
    host.cyc(8'hC6, 32'h00B0B380, 1'b0, 1'b0, -1, r);
    chk("notch", notch, 11'h00B);
    chk("fields", {coding, mode, bip, gain, bo, sb}, 10'h276);
    host.cyc(8'h46, 32'h0, 1'b0, 1'b0, -1, r);
    chk("ctl read", r[23:0], 24'hB0B380);
  endtask
  task t_sample;
    chk("fifo room", crdy, 1'b1);
    push(24'h123456);
    chk("ready low", rdy_n, 1'b0);
    host.cyc(8'h42, 32'h0, 1'b0, 1'b0, -1, r);
    chk("result twos", r[23:0], 24'h563412);
    chk("ready high", rdy_n, 1'b1);
    host.cyc(8'h82, 32'hFF, 1'b0, 1'b0, -1, r);
    host.cyc(8'h42, 32'h0, 1'b0, 1'b0, -1, r);
    chk("result kept", r[23:0], 24'h563412);
    host.cyc(8'h86, 32'h00, 1'b0, 1'b0, -1, r);
    push(24'h123456);
    host.cyc(8'h42, 32'h0, 1'b0, 1'b0, -1, r);
    chk("result offset", r[23:0], 24'h563492);
  endtask
  task t_order;
    host.cyc(8'h84, 32'hB6, 1'b0, 1'b0, -1, r);
    host.cyc(8'hC8, 32'h00A5C3E1, 1'b1, 1'b0, -1, r);
    chk("offset cal", offc, 24'hA5C3E1);
    host.cyc(8'h9C, 32'h3C, 1'b1, 1'b0, -1, r);
    chk("fs cal", {posc, negc}, 48'h00000000003C);
    host.cyc(8'h84, 32'hB7, 1'b1, 1'b0, -1, r);
    host.cyc(8'h48, 32'h0, 1'b1, 1'b1, -1, r);
    chk("offset 3-wire", r[23:0], 24'hA5C3E1);
  endtask
  task t_notch;
    int n;
    n = 0;
    for (int k = 0; k < 7000 && tick !== 1'b1; k++) @(negedge clk);
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 7000);
    chk("tick period", n, 11 * `NOTCH_DIV);
  endtask
  task t_standby;
    host.cyc(8'h84, 32'hBF, 1'b1, 1'b0, -1, r);
    push(24'h000777);
    chk("standby ready", {sb, rdy_n}, 2'b11);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset_read;
    t_ctl_write;
    t_sample;
    t_order;
    t_notch;
    t_standby;
    complete_run;
  end
endmodule
`default_nettype wire

// *** test/host_shift_model.sv ***
// Host side of the serial port: select, shift clock and data line
`timescale 1ns/10ps
`default_nettype none
module host_shift_model (
  // Clock and device pins
  input  wire logic clk_i,
  input  wire logic dev_d_i,
  input  wire logic dev_oe_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  // Host drives
  output var logic  sclk_o,
  output var logic  sel_n_o,
  output wire logic line_o
);
  logic hd = 1'b0;
  logic hoe = 1'b0;
  logic lastd = 1'b0;
  logic lasts = 1'b0;
  // Undriven lines toggle so a stale bit never reads as good data
  wire  sdo_w = sdo_oe_i ? sdo_i : ~lasts;
  assign line_o = dev_oe_i ? dev_d_i : hoe ? hd : ~lastd;
  initial sclk_o = 1'b0;
  initial sel_n_o = 1'b1;
  always @(posedge clk_i) begin
    lastd <= line_o;
    lasts <= sdo_w;
  end
  task half;
    repeat (4) @(negedge clk_i);
  endtask
  // Bytes go first-in at bits 7:0; pz pauses select before that bit
  task automatic cyc(input [7:0] ins, input [31:0] tx, input lsb,
                     input three, input int pz, output [31:0] rx);
    int   n;
    int   k;
    logic [7:0] b;
    n = 8 * int'(ins[6:5]) + 16;
    rx = 32'h00000000;
    sel_n_o = 1'b0;
    half;
    for (int i = 0; i < n; i++) begin
      b = i < 8 ? ins : tx[(i / 8 - 1) * 8 +: 8];
      k = lsb ? i % 8 : 7 - i % 8;
      if (i == pz) begin
        sel_n_o = 1'b1;
        repeat (8) @(negedge clk_i);
        sel_n_o = 1'b0;
      end
      hoe = ins[7] || i < 8;
      hd = b[k];
      half;
      if (i >= 8) rx[(i / 8 - 1) * 8 + k] = three ? sdo_w : line_o;
      sclk_o = 1'b1;
      half;
      sclk_o = 1'b0;
    end
    half;
    hoe = 1'b0;
    sel_n_o = 1'b1;
    half;
  endtask
endmodule
`default_nettype wire
